// File: core/ddr2_ctl_pkg.sv
// Package for the DDR2 state and command control block
// Assumes a single 125 MHz clock domain and an Avalon-MM register slave
package ddr2_ctl_pkg;
   localparam int unsigned ADDR_W          = 8;
   localparam logic [7:0]  OFS_STATE_CMD   = 8'h04;
   localparam logic [7:0]  OFS_MODE_VAL01  = 8'h08;
   localparam logic [7:0]  OFS_MODE_VAL23  = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h20;
   localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h24;
   localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h28;

   localparam int unsigned BIT_INIT        = 0;
   localparam int unsigned BIT_MRS         = 1;
   localparam int unsigned BIT_SRF_ENTER   = 2;
   localparam int unsigned BIT_SRF_EXIT    = 3;
   localparam int unsigned BIT_TGT_LO      = 4;
   localparam int unsigned BIT_INIT_OK     = 8;
   localparam int unsigned BIT_INIT_STATE  = 9;
   localparam int unsigned BIT_SRF_STATE   = 10;
   localparam int unsigned BIT_MC_Q_EMPTY  = 14;
   localparam int unsigned BIT_BUS_Q_EMPTY = 15;
   localparam int unsigned BIT_WARM        = 24;

   // Interrupt status layout: one sticky bit per completed command
   localparam int unsigned IRQ_W           = 5;
   localparam int unsigned IRQ_INIT        = 0;
   localparam int unsigned IRQ_MRS         = 1;
   localparam int unsigned IRQ_SRF_ENTER   = 2;
   localparam int unsigned IRQ_SRF_EXIT    = 3;
   localparam int unsigned IRQ_WARM        = 4;

   localparam logic [1:0]  TGT_MR          = 2'h0;
   localparam logic [1:0]  TGT_EMR1        = 2'h1;
   localparam logic [1:0]  TGT_EMR2        = 2'h2;
   localparam logic [1:0]  TGT_EMR3        = 2'h3;
   localparam int unsigned MODE_W          = 14;
   localparam logic [13:0] DLL_RESET_MASK  = 14'h0100;

   // Sequencer timing
   localparam int unsigned CLK_MHZ         = 125;
   localparam int unsigned T_INIT_US       = 200;
   localparam int unsigned INIT_CYC        = T_INIT_US * CLK_MHZ;
   localparam int unsigned T_MRD_NS        = 16;
   localparam int unsigned MRD_CYC         = (T_MRD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_XSR_NS        = 200;
   localparam int unsigned XSR_CYC         = (T_XSR_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SRF_CYC         = 4;
   localparam int unsigned CNT_W           = 16;

   localparam logic [2:0]  DDR_CMD_NOP     = 3'h7;
   localparam logic [2:0]  DDR_CMD_MRS     = 3'h0;
   localparam logic [2:0]  DDR_CMD_REF     = 3'h1;
   localparam logic [2:0]  DDR_CMD_PRE     = 3'h2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INIT,
      ST_MRS,
      ST_SRF_ENTER,
      ST_SELF_REFRESH,
      ST_SRF_EXIT,
      ST_WARM
   } seq_state_t;
endpackage

// File: core/ddr2_ctl_sync.sv
// Three-stage synchroniser for one level from outside the clock domain
// Assumes the level is stable for at least three clock periods per change
`timescale 1ns/1ps
module ddr2_ctl_sync
#(
   parameter logic RST_VAL = 1'b0
)
(
   input  wire logic mclk_in,
   input  wire logic arst_n_in,
   input  wire logic async_in,
   output logic      level_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s1_r      <= RST_VAL;
         s2_r      <= RST_VAL;
         s3_r      <= RST_VAL;
         level_out <= RST_VAL;
      end
      else
      begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // A change counts only once the last two stages agree
         if (s2_r == s3_r)
            level_out <= s3_r;
      end
   end
endmodule

// File: core/ddr2_state_command_control.sv
// State and command control sequencer for a DDR2 memory controller
// Assumes Avalon-MM master on mclk_in; queue-empty and PHY calibration status come from other clock domains
`timescale 1ns/1ps
module ddr2_state_command_control
import ddr2_ctl_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = ddr2_ctl_pkg::INIT_CYC
)
(
   input  wire logic                           mclk_in,
   input  wire logic                           arst_n_in,
   input  wire logic [ddr2_ctl_pkg::ADDR_W-1:0] avs_address_in,
   input  wire logic                           avs_read_in,
   input  wire logic                           avs_write_in,
   input  wire logic [31:0]                    avs_writedata_in,
   input  wire logic [3:0]                     avs_byteenable_in,
   output logic [31:0]                         avs_readdata_out,
   output logic                                avs_waitrequest_out,
   input  wire logic                           bus_q_empty_in,
   input  wire logic                           mc_q_empty_in,
   output logic                                phy_cal_start_out,
   input  wire logic                           phy_cal_done_in,
   output logic [2:0]                          ddr_cmd_out,
   output logic [1:0]                          ddr_ba_out,
   output logic [ddr2_ctl_pkg::MODE_W-1:0]     ddr_addr_out,
   output logic                                ddr_cke_out,
   output logic                                irq_out
);
   import ddr2_ctl_pkg::*;

   seq_state_t        state_r;
   logic [CNT_W-1:0]  cnt_r;
   logic [31:0]       init_cnt_r;
   logic              init_done_r;
   logic              cal_done_seen_r;
   logic              cmd_init_r;
   logic              cmd_mrs_r;
   logic              cmd_srf_in_r;
   logic              cmd_srf_out_r;
   logic              cmd_warm_r;
   logic [1:0]        tgt_r;
   logic [MODE_W-1:0] mode_val_r [4];
   logic              init_ok_r;
   logic              srf_flag_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_en_r;
   logic [IRQ_W-1:0]  done_evt;
   logic              ack_r;
   logic              bus_q_empty_s;
   logic              mc_q_empty_s;
   logic              cal_done_s;
   logic              wr_go;
   logic              rd_go;
   logic              cmd_busy;

   ddr2_ctl_sync #(.RST_VAL(1'b1)) u_sync_busq
   (
      .mclk_in   (mclk_in),
      .arst_n_in (arst_n_in),
      .async_in  (bus_q_empty_in),
      .level_out (bus_q_empty_s)
   );

   ddr2_ctl_sync #(.RST_VAL(1'b1)) u_sync_mcq
   (
      .mclk_in   (mclk_in),
      .arst_n_in (arst_n_in),
      .async_in  (mc_q_empty_in),
      .level_out (mc_q_empty_s)
   );

   ddr2_ctl_sync #(.RST_VAL(1'b0)) u_sync_cal
   (
      .mclk_in   (mclk_in),
      .arst_n_in (arst_n_in),
      .async_in  (phy_cal_done_in),
      .level_out (cal_done_s)
   );

   // One wait state per access: waitrequest drops in the cycle after a request appears
   // Read data is loaded as the request is first seen so it stands while waitrequest is low
   assign wr_go    = avs_write_in && ack_r;
   assign rd_go    = avs_read_in && !ack_r;
   assign cmd_busy = cmd_init_r | cmd_mrs_r | cmd_srf_in_r | cmd_srf_out_r | cmd_warm_r;

   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ack_r               <= 1'b0;
         avs_waitrequest_out <= 1'b1;
      end
      else
      begin
         ack_r               <= (avs_read_in || avs_write_in) && !ack_r;
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_r);
      end
   end

   // Command bits: write one sets, write zero ignored; completion clears
   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cmd_init_r    <= 1'b0;
         cmd_mrs_r     <= 1'b0;
         cmd_srf_in_r  <= 1'b0;
         cmd_srf_out_r <= 1'b0;
         cmd_warm_r    <= 1'b0;
         tgt_r         <= TGT_MR;
      end
      else
      begin
         if (done_evt[IRQ_INIT])
            cmd_init_r <= 1'b0;
         if (done_evt[IRQ_MRS])
            cmd_mrs_r <= 1'b0;
         if (done_evt[IRQ_SRF_ENTER])
            cmd_srf_in_r <= 1'b0;
         if (done_evt[IRQ_SRF_EXIT])
            cmd_srf_out_r <= 1'b0;
         if (done_evt[IRQ_WARM])
            cmd_warm_r <= 1'b0;
         // New commands are taken only while no command bit is set so a running one stays visible as busy
         if (wr_go && avs_address_in == OFS_STATE_CMD && !cmd_busy)
         begin
            if (avs_byteenable_in[0])
            begin
               tgt_r <= avs_writedata_in[BIT_TGT_LO+:2];
               // Init wins if software breaks the one-command discipline
               if (avs_writedata_in[BIT_INIT])
                  cmd_init_r <= 1'b1;
               else if (avs_writedata_in[BIT_MRS])
                  cmd_mrs_r <= 1'b1;
               else if (avs_writedata_in[BIT_SRF_ENTER])
                  cmd_srf_in_r <= 1'b1;
               else if (avs_writedata_in[BIT_SRF_EXIT])
                  cmd_srf_out_r <= 1'b1;
            end
            if (avs_byteenable_in[3] && avs_writedata_in[BIT_WARM] && !(avs_byteenable_in[0]
                && |avs_writedata_in[BIT_SRF_EXIT:BIT_INIT]))
               cmd_warm_r <= 1'b1;
         end
      end
   end

   // Mode values, two per word in the low and high halves
   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         for (int i = 0; i < 4; i++)
            mode_val_r[i] <= '0;
      end
      else if (wr_go && (avs_address_in == OFS_MODE_VAL01 || avs_address_in == OFS_MODE_VAL23))
      begin
         if (avs_byteenable_in[0] && avs_byteenable_in[1])
            mode_val_r[{avs_address_in == OFS_MODE_VAL23, 1'b0}] <= avs_writedata_in[MODE_W-1:0];
         if (avs_byteenable_in[2] && avs_byteenable_in[3])
            mode_val_r[{avs_address_in == OFS_MODE_VAL23, 1'b1}] <= avs_writedata_in[16+:MODE_W];
      end
   end

   // Sequencer
   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_r           <= ST_IDLE;
         cnt_r             <= '0;
         init_cnt_r        <= '0;
         init_done_r       <= 1'b0;
         cal_done_seen_r   <= 1'b0;
         init_ok_r         <= 1'b0;
         srf_flag_r        <= 1'b0;
         phy_cal_start_out <= 1'b0;
         ddr_cmd_out       <= DDR_CMD_NOP;
         ddr_ba_out        <= 2'h0;
         ddr_addr_out      <= '0;
         ddr_cke_out       <= 1'b0;
         done_evt          <= '0;
      end
      else
      begin
         done_evt    <= '0;
         ddr_cmd_out <= DDR_CMD_NOP;
         unique case (state_r)
            ST_IDLE:
            begin
               if (cmd_init_r && !done_evt[IRQ_INIT])
               begin
                  state_r           <= ST_INIT;
                  init_cnt_r        <= '0;
                  init_done_r       <= 1'b0;
                  cal_done_seen_r   <= 1'b0;
                  init_ok_r         <= 1'b0;
                  phy_cal_start_out <= 1'b1;
                  ddr_cke_out       <= 1'b0;
               end
               else if (cmd_mrs_r && !done_evt[IRQ_MRS])
               begin
                  state_r      <= ST_MRS;
                  cnt_r        <= CNT_W'(MRD_CYC);
                  ddr_cmd_out  <= DDR_CMD_MRS;
                  ddr_ba_out   <= tgt_r;
                  ddr_addr_out <= mode_val_r[tgt_r];
               end
               else if (cmd_srf_in_r && !done_evt[IRQ_SRF_ENTER] && !srf_flag_r)
               begin
                  state_r     <= ST_SRF_ENTER;
                  cnt_r       <= CNT_W'(SRF_CYC);
                  ddr_cmd_out <= DDR_CMD_REF;
                  ddr_cke_out <= 1'b0;
               end
               else if (cmd_srf_in_r && !done_evt[IRQ_SRF_ENTER])
                  done_evt[IRQ_SRF_ENTER] <= 1'b1;
               else if (cmd_srf_out_r && !done_evt[IRQ_SRF_EXIT])
                  done_evt[IRQ_SRF_EXIT] <= 1'b1;
               else if (cmd_warm_r && !done_evt[IRQ_WARM])
               begin
                  // Memory assumed parked in self-refresh; just wake it
                  state_r     <= ST_WARM;
                  cnt_r       <= CNT_W'(XSR_CYC);
                  ddr_cke_out <= 1'b1;
               end
            end
            ST_INIT:
            begin
               phy_cal_start_out <= 1'b0;
               if (cal_done_s)
                  cal_done_seen_r <= 1'b1;
               if (!init_done_r)
               begin
                  init_cnt_r <= init_cnt_r + 32'h1;
                  if (init_cnt_r == INIT_CYCLES / 2)
                     ddr_cke_out <= 1'b1;
                  if (init_cnt_r == INIT_CYCLES - 3)
                     ddr_cmd_out <= DDR_CMD_PRE;
                  if (init_cnt_r == INIT_CYCLES - 2)
                  begin
                     ddr_cmd_out  <= DDR_CMD_MRS;
                     ddr_ba_out   <= TGT_MR;
                     // DLL reset forced regardless of the programmed value
                     ddr_addr_out <= mode_val_r[TGT_MR] | DLL_RESET_MASK;
                  end
                  if (init_cnt_r == INIT_CYCLES - 1)
                     init_done_r <= 1'b1;
               end
               if (init_done_r && (cal_done_seen_r || cal_done_s))
               begin
                  init_ok_r          <= 1'b1;
                  srf_flag_r         <= 1'b0;
                  done_evt[IRQ_INIT] <= 1'b1;
                  state_r            <= ST_IDLE;
               end
            end
            ST_MRS, ST_SRF_ENTER, ST_WARM:
            begin
               cnt_r <= cnt_r - CNT_W'(1);
               if (cnt_r == CNT_W'(1))
               begin
                  state_r <= (state_r == ST_SRF_ENTER) ? ST_SELF_REFRESH : ST_IDLE;
                  if (state_r == ST_MRS)
                     done_evt[IRQ_MRS] <= 1'b1;
                  else if (state_r == ST_SRF_ENTER)
                  begin
                     srf_flag_r              <= 1'b1;
                     done_evt[IRQ_SRF_ENTER] <= 1'b1;
                  end
                  else
                  begin
                     srf_flag_r         <= 1'b0;
                     init_ok_r          <= 1'b1;
                     done_evt[IRQ_WARM] <= 1'b1;
                  end
               end
            end
            ST_SELF_REFRESH:
            begin
               if (cmd_srf_out_r)
               begin
                  state_r     <= ST_SRF_EXIT;
                  cnt_r       <= CNT_W'(XSR_CYC);
                  ddr_cke_out <= 1'b1;
               end
               // Entry requested while already parked completes at once instead of hanging
               else if (cmd_srf_in_r && !done_evt[IRQ_SRF_ENTER])
                  done_evt[IRQ_SRF_ENTER] <= 1'b1;
               else if (cmd_init_r || cmd_warm_r)
                  state_r <= ST_IDLE;
            end
            ST_SRF_EXIT:
            begin
               cnt_r <= cnt_r - CNT_W'(1);
               if (cnt_r == CNT_W'(1))
               begin
                  srf_flag_r             <= 1'b0;
                  done_evt[IRQ_SRF_EXIT] <= 1'b1;
                  state_r                <= ST_IDLE;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // Interrupts: a set in the same cycle as a clear wins
   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         irq_stat_r <= '0;
         irq_en_r   <= '0;
         irq_out    <= 1'b0;
      end
      else
      begin
         if (wr_go && avs_address_in == OFS_IRQ_ENABLE && avs_byteenable_in[0])
            irq_en_r <= avs_writedata_in[IRQ_W-1:0];
         if (wr_go && avs_address_in == OFS_IRQ_CLEAR && avs_byteenable_in[0])
            irq_stat_r <= (irq_stat_r & ~avs_writedata_in[IRQ_W-1:0]) | done_evt;
         else
            irq_stat_r <= irq_stat_r | done_evt;
         irq_out <= |(irq_stat_r & irq_en_r);
      end
   end

   // Read data; unmapped and write-only addresses read zero
   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         avs_readdata_out <= '0;
      else if (rd_go)
      begin
         avs_readdata_out <= '0;
         unique case (avs_address_in)
            OFS_STATE_CMD:
            begin
               avs_readdata_out[BIT_INIT]        <= cmd_init_r;
               avs_readdata_out[BIT_MRS]         <= cmd_mrs_r;
               avs_readdata_out[BIT_SRF_ENTER]   <= cmd_srf_in_r;
               avs_readdata_out[BIT_SRF_EXIT]    <= cmd_srf_out_r;
               avs_readdata_out[BIT_TGT_LO+:2]   <= tgt_r;
               avs_readdata_out[BIT_INIT_OK]     <= init_ok_r;
               avs_readdata_out[BIT_INIT_STATE]  <= (state_r == ST_INIT);
               avs_readdata_out[BIT_SRF_STATE]   <= srf_flag_r;
               avs_readdata_out[BIT_MC_Q_EMPTY]  <= mc_q_empty_s;
               avs_readdata_out[BIT_BUS_Q_EMPTY] <= bus_q_empty_s;
               avs_readdata_out[BIT_WARM]        <= cmd_warm_r;
            end
            OFS_MODE_VAL01:
               avs_readdata_out <= {2'h0, mode_val_r[1], 2'h0, mode_val_r[0]};
            OFS_MODE_VAL23:
               avs_readdata_out <= {2'h0, mode_val_r[3], 2'h0, mode_val_r[2]};
            OFS_IRQ_STATUS:
               avs_readdata_out[IRQ_W-1:0] <= irq_stat_r;
            OFS_IRQ_ENABLE:
               avs_readdata_out[IRQ_W-1:0] <= irq_en_r;
            default:
               avs_readdata_out <= '0;
         endcase
      end
   end
endmodule

// File: verification/ddr2_ctl_checker.sv
// Port-level assertions for the DDR2 state and command control block
// Assumes it is bound to the top module; one clock, active-low async reset
`timescale 1ns/1ps
module ddr2_ctl_checker
import ddr2_ctl_pkg::*;
(
   input wire logic        mclk_in,
   input wire logic        arst_n_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        phy_cal_start_out,
   input wire logic [2:0]  ddr_cmd_out,
   input wire logic        ddr_cke_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);

   sequence req_s;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence ack_s;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence

   one_wait_a: assert property (req_s |=> ack_s)
      else $error("bus access not answered after one wait state");
   idle_wait_a: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
      else $error("waitrequest low without a request");
   ack_cause_a: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
      else $error("acknowledge without a preceding request");
   rdata_hold_a: assert property (!(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
      else $error("read data changed without a read");
   cal_pulse_a: assert property (phy_cal_start_out |=> !phy_cal_start_out)
      else $error("calibration start longer than one cycle");
   mrs_single_a: assert property (ddr_cmd_out == DDR_CMD_MRS |=> ddr_cmd_out != DDR_CMD_MRS)
      else $error("mode set command held too long");
   mrs_cke_a: assert property (ddr_cmd_out == DDR_CMD_MRS |-> ddr_cke_out)
      else $error("mode set issued with clock enable low");
   srf_cke_a: assert property (ddr_cmd_out == DDR_CMD_REF |-> ##[0:2] !ddr_cke_out)
      else $error("clock enable not dropped on self-refresh entry");
endmodule

// File: verification/ddr2_sdram_model.sv
// Behavioural memory and PHY calibration model at the far side of the block
// Assumes commands are sampled on the controller clock
`timescale 1ns/1ps
module ddr2_sdram_model
import ddr2_ctl_pkg::*;
#(
   parameter int CAL_LAT = 60
)
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        cal_start_in,
   input  wire logic [2:0]  cmd_in,
   input  wire logic [1:0]  ba_in,
   input  wire logic [13:0] addr_in,
   input  wire logic        cke_in,
   output logic             cal_done_out
);
   logic [13:0] mr [4];
   logic        dll_seen;
   int          cal_cnt;

   // Slow calibration so that a sequencer ignoring it finishes too early
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cal_cnt      <= 0;
         cal_done_out <= 1'b0;
      end
      else if (cal_start_in)
      begin
         cal_cnt      <= CAL_LAT;
         cal_done_out <= 1'b0;
      end
      else if (cal_cnt == 1)
      begin
         cal_cnt      <= 0;
         cal_done_out <= 1'b1;
      end
      else if (cal_cnt > 1)
         cal_cnt <= cal_cnt - 1;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         dll_seen <= 1'b0;
      else if (cmd_in == DDR_CMD_MRS && cke_in && ba_in == TGT_MR && addr_in[8])
         dll_seen <= 1'b1;
   end

   always_ff @(posedge clk_in)
   begin
      if (cmd_in == DDR_CMD_MRS && cke_in)
         mr[ba_in] <= addr_in;
   end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the DDR2 state and command control block
// Assumes the Avalon-MM slave answers after one wait state
`timescale 1ns/1ps
module testbench;
   import ddr2_ctl_pkg::*;
   logic        clk, rst_n, rd, wr, bq, mq, cal_start, cal_done, cke, irq, wreq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, got, seen;
   logic [3:0]  be;
   logic [2:0]  cmd;
   logic [1:0]  ba;
   logic [13:0] ma;
   int          mismatches, cmp_count;

   ddr2_state_command_control #(.INIT_CYCLES(20)) i_dut (.mclk_in(clk), .arst_n_in(rst_n),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .bus_q_empty_in(bq), .mc_q_empty_in(mq), .phy_cal_start_out(cal_start), .phy_cal_done_in(cal_done),
      .ddr_cmd_out(cmd), .ddr_ba_out(ba), .ddr_addr_out(ma), .ddr_cke_out(cke), .irq_out(irq));
   ddr2_sdram_model i_mem (.clk_in(clk), .rst_n_in(rst_n), .cal_start_in(cal_start), .cmd_in(cmd),
      .ba_in(ba), .addr_in(ma), .cke_in(cke), .cal_done_out(cal_done));

   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      @(posedge clk);
      while (wreq !== 1'b0)
         @(posedge clk);
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // Issue a command and poll its bit until it drops
   task run(input logic [31:0] c, input logic [31:0] m);
      seen = 32'h0;
      bus(1'b1, OFS_STATE_CMD, c);
      repeat (300)
      begin
         bus(1'b0, OFS_STATE_CMD, 32'h0);
         seen |= got;
         if ((got & m) === 32'h0)
            break;
      end
      chk(got & m, 32'h0);
   endtask

   task t_reset;
      bus(1'b0, OFS_STATE_CMD, 32'h0);
      chk(got, 32'h0000C000);
      bus(1'b0, 8'h40, 32'h0);
      chk(got, 32'h0);
      bq <= 1'b0;
      repeat (8) @(posedge clk);
      bus(1'b0, OFS_STATE_CMD, 32'h0);
      chk(got, 32'h00004000);
      bq <= 1'b1;
      mq <= 1'b0;
      repeat (8) @(posedge clk);
      bus(1'b0, OFS_STATE_CMD, 32'h0);
      chk(got, 32'h00008000);
      mq <= 1'b1;
      $display("test reset and flags done");
   endtask

   task t_init;
      bus(1'b1, OFS_MODE_VAL01, 32'h00440432);
      bus(1'b1, OFS_MODE_VAL23, 32'h00010080);
      run(32'h1, 32'h1);
      chk(seen & 32'h201, 32'h201);
      chk(got, 32'h0000C100);
      chk({31'h0, cal_done}, 32'h1);
      chk({31'h0, i_mem.dll_seen}, 32'h1);
      $display("test init done");
   endtask

   task t_mrs;
      logic [13:0] e [4];
      e = '{14'h0432, 14'h0044, 14'h0080, 14'h0001};
      for (int t = 0; t < 4; t++)
      begin
         run({26'h0, 2'(t), 4'h2}, 32'h2);
         chk({18'h0, i_mem.mr[t]}, {18'h0, e[t]});
      end
      $display("test mode set done");
   endtask

   task t_irq;
      bus(1'b1, OFS_IRQ_CLEAR, 32'h1F);
      bus(1'b1, OFS_IRQ_ENABLE, 32'h2);
      run(32'h12, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, OFS_IRQ_CLEAR, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
      run(32'h12, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk(got & 32'h2, 32'h2);
      bus(1'b0, OFS_IRQ_CLEAR, 32'h0);
      chk(got, 32'h0);
      $display("test interrupt done");
   endtask

   task t_srf;
      run(32'h4, 32'h4);
      chk(got, 32'h0000C500);
      chk({31'h0, cke}, 32'h0);
      run(32'h4, 32'h4);
      chk(got, 32'h0000C500);
      bus(1'b1, OFS_STATE_CMD, 32'h0);
      bus(1'b0, OFS_STATE_CMD, 32'h0);
      chk(got, 32'h0000C500);
      run(32'h8, 32'h8);
      chk(got, 32'h0000C100);
      chk({31'h0, cke}, 32'h1);
      $display("test self-refresh done");
   endtask

   // Warm start straight after a reset must come up without any init sequence
   task t_warm;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({31'h0, cke}, 32'h0);
      rst_n <= 1'b1;
      run(32'h01000000, 32'h01000000);
      chk(got, 32'h0000C100);
      chk({30'h0, i_mem.dll_seen, cke}, 32'h1);
      $display("test warm start done");
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      #160000;
      mismatches++;
      tally_and_finish;
   end

   initial
   begin
      {rst_n, rd, wr, addr, wdata} = '0;
      {be, bq, mq} = 6'h3F;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_init;
      t_mrs;
      t_irq;
      t_srf;
      t_warm;
      tally_and_finish;
   end
endmodule

bind ddr2_state_command_control ddr2_ctl_checker u_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .phy_cal_start_out(phy_cal_start_out),
   .ddr_cmd_out(ddr_cmd_out), .ddr_cke_out(ddr_cke_out));
